// >>> rtl/fps_sequencer.sv
// Host-side program/status sequencer for an asynchronous NOR flash
// Rules this project covers
// RL1 - Protection program: C0h, then address and data
// RL2 - Poll until ready; toggle enables between reads
// RL3 - Check locked, supply and fail status bits
// RL4 - Error bits stay sticky across several operations
// RL5 - Clear status after error before further programs
// RL6 - Two-word addresses differ only in bit zero
// RL7 - Four-word addresses differ only in bits zero/one
// RL8 - Lock word at 80h, then unique number
// RL9 - Query 44h returns 0080h, lock word location
// RL10 - Query sizes encoded as power-of-two bytes
// RL11 - Eight user one-time words follow unique number
`timescale 1ns/100ps
`default_nettype none
`include "fps_regs.svh"
module fps_sequencer
   import fps_pkg::*;
#(
   parameter int ADDR_W = 22
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   output logic [ADDR_W-1:0] flash_addr,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   output logic [15:0] flash_dq_out,
   output logic flash_dq_oe,
   input wire logic [15:0] flash_dq_in
);
   // Software-visible state
   logic [ADDR_W-1:0] addr_reg, addr_next; // Base target address
   logic [15:0] data_reg [0:3]; // Words to program, one per slot
   logic [15:0] data_next [0:3];
   fps_mode_type mode_reg, mode_next; // Program kind
   logic [7:0] status_reg, status_next; // Last flash status byte
   logic [2:0] irq_reg, irq_next; // Sticky events
   logic [2:0] mask_reg, mask_next; // Interrupt mask
   logic err_seen_reg, err_seen_next; // Error not yet cleared
   // Sequencer state
   fps_state_type state_reg, state_next;
   logic [3:0] cnt_reg, cnt_next; // Phase timer
   logic [1:0] word_reg, word_next; // Word within a multi-word op
   logic phase_reg, phase_next; // 0 strobe asserted, 1 released
   // Flash pin registers
   logic [ADDR_W-1:0] fa_reg, fa_next;
   logic ce_n_reg, ce_n_next, oe_n_reg, oe_n_next, we_n_reg, we_n_next;
   logic [15:0] dq_reg, dq_next;
   logic dqoe_reg, dqoe_next;
   // Bus answer registers
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next, pslverr_reg, pslverr_next;
   // Local wires
   logic bus_wr, bus_rd, start_cmd, clear_cmd, err_bits;
   logic [2:0] ev_set;
   logic [1:0] last_word;
   logic [ADDR_W-1:0] word_addr;

   // One-cycle access phase: answer comes the edge after penable rises
   always_comb begin
      bus_wr = psel && penable && pwrite && !pready_reg;
      bus_rd = psel && penable && !pwrite && !pready_reg;
   end

   // Command decode from a control write
   always_comb begin
      start_cmd = bus_wr && paddr == `FPS_CTRL_OFF &&
         pwdata[`FPS_CTRL_START];
      clear_cmd = bus_wr && paddr == `FPS_CTRL_OFF &&
         pwdata[`FPS_CTRL_CLEAR];
   end

   // Status error bits that force a clear before the next program
   assign err_bits = status_reg[`FPS_SR_LOCKED] |
      status_reg[`FPS_SR_SUPPLY] | status_reg[`FPS_SR_FAIL]; // RL3

   // Words per operation and address of the current word
   always_comb begin
      case (mode_reg)
         FPS_MODE_TWO: last_word = 2'h1;
         FPS_MODE_FOUR: last_word = 2'h3;
         default: last_word = 2'h0;
      endcase
      word_addr = addr_reg;
      // Low bits come from the word count, the rest stay fixed
      if (mode_reg == FPS_MODE_TWO) begin
         word_addr[0] = word_reg[0]; // RL6
      end else if (mode_reg == FPS_MODE_FOUR) begin
         word_addr[1:0] = word_reg; // RL7
      end
   end

   // Sequencer: writes, polling, status clear
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      word_next = word_reg;
      phase_next = phase_reg;
      fa_next = fa_reg;
      ce_n_next = ce_n_reg;
      oe_n_next = oe_n_reg;
      we_n_next = we_n_reg;
      dq_next = dq_reg;
      dqoe_next = dqoe_reg;
      status_next = status_reg;
      err_seen_next = err_seen_reg;
      ev_set = 3'h0;
      if (cnt_reg != 4'h0) begin
         cnt_next = cnt_reg - 4'h1;
      end
      case (state_reg)
         FPS_IDLE: begin
            if (clear_cmd) begin
               state_next = FPS_CLEAR;
               phase_next = 1'b0;
               cnt_next = `FPS_PHASE_CYC;
            end else if (start_cmd && err_seen_reg) begin
               // Refuse further programs until status is cleared
               ev_set[`FPS_IRQ_REFUSE] = 1'b1; // RL5
            end else if (start_cmd) begin
               state_next = FPS_WSETUP;
               word_next = 2'h0;
               phase_next = 1'b0;
               cnt_next = `FPS_PHASE_CYC;
            end
         end
         FPS_WSETUP, FPS_WDATA, FPS_CLEAR, FPS_ARRAY: begin
            // Write cycle: strobe low for a phase, then high for a phase
            if (phase_reg == 1'b0) begin
               ce_n_next = 1'b0;
               we_n_next = 1'b0;
               dqoe_next = 1'b1;
               oe_n_next = 1'b1;
               if (state_reg == FPS_WDATA) begin
                  fa_next = word_addr;
                  dq_next = data_reg[word_reg];
               end else begin
                  fa_next = addr_reg;
                  if (state_reg == FPS_CLEAR) begin
                     dq_next = `FPS_CMD_CLR_STATUS; // RL5
                  end else if (state_reg == FPS_ARRAY) begin
                     dq_next = `FPS_CMD_READ_ARRAY;
                  end else if (mode_reg == FPS_MODE_PROT) begin
                     dq_next = `FPS_CMD_PROT_SETUP; // RL1
                  end else begin
                     dq_next = `FPS_CMD_PROG_SETUP;
                  end
               end
               if (cnt_reg == 4'h0) begin
                  phase_next = 1'b1;
                  cnt_next = `FPS_PHASE_CYC;
                  we_n_next = 1'b1;
                  ce_n_next = 1'b1;
               end
            end else if (cnt_reg == 4'h0) begin
               dqoe_next = 1'b0;
               phase_next = 1'b0;
               cnt_next = `FPS_PHASE_CYC;
               case (state_reg)
                  FPS_WSETUP: state_next = FPS_WDATA;
                  FPS_WDATA: begin
                     // Multi-word ops send every word before polling
                     if (word_reg == last_word) begin
                        state_next = FPS_POLL; // RL1
                     end else begin
                        word_next = word_reg + 2'h1;
                     end
                  end
                  FPS_CLEAR: begin
                     err_seen_next = 1'b0;
                     status_next = 8'h00;
                     state_next = FPS_ARRAY;
                  end
                  default: state_next = FPS_IDLE;
               endcase
            end
         end
         FPS_POLL: begin
            // Read status with both enables low, sample at phase end
            ce_n_next = 1'b0;
            oe_n_next = 1'b0;
            if (cnt_reg == 4'h0) begin
               status_next = flash_dq_in[7:0];
               ce_n_next = 1'b1;
               oe_n_next = 1'b1; // RL2
               cnt_next = `FPS_PHASE_CYC;
               state_next = FPS_GAP;
            end
         end
         FPS_GAP: begin
            // Enables stay high a phase so the next read refreshes
            if (cnt_reg == 4'h0) begin
               cnt_next = `FPS_PHASE_CYC;
               if (!status_reg[`FPS_SR_READY]) begin
                  state_next = FPS_POLL; // RL2
               end else begin
                  // Errors stay recorded until a clear
                  ev_set[`FPS_IRQ_DONE] = 1'b1;
                  if (err_bits) begin
                     err_seen_next = 1'b1; // RL3 RL4
                     ev_set[`FPS_IRQ_ERR] = 1'b1;
                  end
                  state_next = FPS_ARRAY;
               end
            end
         end
         default: state_next = FPS_IDLE;
      endcase
   end

   // Register file: writes and read mux
   always_comb begin
      addr_next = addr_reg;
      mode_next = mode_reg;
      mask_next = mask_reg;
      for (int i = 0; i < 4; i++) begin
         data_next[i] = data_reg[i];
      end
      // Set wins over a write-one clear
      irq_next = irq_reg | ev_set;
      prdata_next = prdata_reg;
      pready_next = 1'b0;
      pslverr_next = 1'b0;
      if (bus_wr || bus_rd) begin
         pready_next = 1'b1;
         prdata_next = 32'h0;
      end
      if (bus_wr) begin
         case (paddr)
            `FPS_CTRL_OFF: begin
               if (state_reg == FPS_IDLE) begin
                  mode_next = fps_mode_type'(
                     pwdata[`FPS_CTRL_MODE_HI:`FPS_CTRL_MODE_LO]);
               end
            end
            `FPS_ADDR_OFF: addr_next = pwdata[ADDR_W-1:0];
            `FPS_DATA_OFF: data_next[pwdata[17:16]] = pwdata[15:0];
            `FPS_IRQ_OFF: irq_next = (irq_reg & ~pwdata[2:0]) | ev_set;
            `FPS_MASK_OFF: mask_next = pwdata[2:0];
            default: pslverr_next = 1'b1;
         endcase
      end
      if (bus_rd) begin
         case (paddr)
            `FPS_CTRL_OFF: prdata_next = {28'h0, mode_reg, 2'h0};
            `FPS_ADDR_OFF: prdata_next = 32'(addr_reg);
            `FPS_STAT_OFF: prdata_next = {16'h0, 6'h0, err_seen_reg,
               state_reg == FPS_IDLE, status_reg};
            `FPS_IRQ_OFF: prdata_next = {29'h0, irq_reg};
            `FPS_MASK_OFF: prdata_next = {29'h0, mask_reg};
            default: pslverr_next = 1'b1;
         endcase
      end
   end

   // State registers
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg <= FPS_IDLE;
         cnt_reg <= 4'h0;
         word_reg <= 2'h0;
         phase_reg <= 1'b0;
         fa_reg <= '0;
         ce_n_reg <= 1'b1;
         oe_n_reg <= 1'b1;
         we_n_reg <= 1'b1;
         dq_reg <= 16'h0;
         dqoe_reg <= 1'b0;
         status_reg <= 8'h00;
         err_seen_reg <= 1'b0;
         addr_reg <= '0;
         mode_reg <= FPS_MODE_PROT;
         mask_reg <= 3'h0;
         irq_reg <= 3'h0;
         prdata_reg <= 32'h0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         for (int i = 0; i < 4; i++) begin
            data_reg[i] <= 16'h0;
         end
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         word_reg <= word_next;
         phase_reg <= phase_next;
         fa_reg <= fa_next;
         ce_n_reg <= ce_n_next;
         oe_n_reg <= oe_n_next;
         we_n_reg <= we_n_next;
         dq_reg <= dq_next;
         dqoe_reg <= dqoe_next;
         status_reg <= status_next;
         err_seen_reg <= err_seen_next;
         addr_reg <= addr_next;
         mode_reg <= mode_next;
         mask_reg <= mask_next;
         irq_reg <= irq_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         for (int i = 0; i < 4; i++) begin
            data_reg[i] <= data_next[i];
         end
      end
   end

   // Interrupt level registered so the output comes from a flop
   logic irq_out_reg;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         irq_out_reg <= 1'b0;
      end else begin
         irq_out_reg <= |(irq_next & mask_next);
      end
   end

   // Outputs straight from flops
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign irq = irq_out_reg;
   assign flash_addr = fa_reg;
   assign flash_ce_n = ce_n_reg;
   assign flash_oe_n = oe_n_reg;
   assign flash_we_n = we_n_reg;
   assign flash_dq_out = dq_reg;
   assign flash_dq_oe = dqoe_reg;
endmodule
`default_nettype wire

// >>> shared/fps_regs.svh
// Register offsets, field positions and flash codes for the program sequencer
`ifndef FPS_REGS_SVH
`define FPS_REGS_SVH
// APB register byte offsets
`define FPS_CTRL_OFF 12'h000
`define FPS_ADDR_OFF 12'h004
`define FPS_DATA_OFF 12'h008
`define FPS_STAT_OFF 12'h00c
`define FPS_IRQ_OFF 12'h010
`define FPS_MASK_OFF 12'h014
// Control register fields
`define FPS_CTRL_START 0
`define FPS_CTRL_CLEAR 1
`define FPS_CTRL_MODE_LO 2
`define FPS_CTRL_MODE_HI 3
// Flash command codes
`define FPS_CMD_PROT_SETUP 16'h00c0
`define FPS_CMD_PROG_SETUP 16'h0040
`define FPS_CMD_CLR_STATUS 16'h0050
`define FPS_CMD_READ_ARRAY 16'h00ff
// Flash status bits
`define FPS_SR_READY 7
`define FPS_SR_LOCKED 1
`define FPS_SR_SUPPLY 3
`define FPS_SR_FAIL 4
// Interrupt bits: done, error, refused
`define FPS_IRQ_DONE 0
`define FPS_IRQ_ERR 1
`define FPS_IRQ_REFUSE 2
// Strobe phase length in clocks (8 ns each)
`define FPS_PHASE_CYC 4'd9
`endif

// >>> shared/fps_pkg.sv
// Types shared by the flash program sequencer
package fps_pkg;
   typedef enum logic [1:0] {
      FPS_MODE_PROT = 2'h0,
      FPS_MODE_ONE = 2'h1,
      FPS_MODE_TWO = 2'h2,
      FPS_MODE_FOUR = 2'h3
   } fps_mode_type;
   typedef enum logic [6:0] {
      FPS_IDLE = 7'h01,
      FPS_WSETUP = 7'h02,
      FPS_WDATA = 7'h04,
      FPS_POLL = 7'h08,
      FPS_GAP = 7'h10,
      FPS_CLEAR = 7'h20,
      FPS_ARRAY = 7'h40
   } fps_state_type;
endpackage

// >>> tb/fps_sequencer_chk.sv
// Port-level assertions for the flash program sequencer
`timescale 1ns/100ps
`default_nettype none
module fps_sequencer_chk #(
   parameter int ADDR_W = 22
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic irq,
   input wire logic [ADDR_W-1:0] flash_addr,
   input wire logic flash_ce_n,
   input wire logic flash_oe_n,
   input wire logic flash_we_n,
   input wire logic [15:0] flash_dq_out,
   input wire logic flash_dq_oe,
   input wire logic [15:0] flash_dq_in
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   // Write strobe held low with address and data steady
   sequence wr_low;
      (!flash_we_n && $stable(flash_dq_out) && $stable(flash_addr))[*8];
   endsequence
   // Read strobe held low with the chip selected
   sequence rd_low;
      (!flash_oe_n && !flash_ce_n)[*8];
   endsequence
   apb_answer_a:
      assert property ($rose(penable) && psel |-> !pready ##1 pready)
      else $error("pready not one cycle after penable");
   ready_pulse_a:
      assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   slverr_qual_a:
      assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   no_contention_a:
      assert property (!flash_oe_n |-> flash_we_n && !flash_dq_oe)
      else $error("read while host drives the data bus");
   write_drive_a:
      assert property (!flash_we_n |-> !flash_ce_n && flash_dq_oe)
      else $error("write strobe without select or data");
   write_phase_a:
      assert property ($fell(flash_we_n) |=> wr_low ##1 flash_we_n)
      else $error("write phase not nine cycles");
   read_phase_a:
      assert property ($fell(flash_oe_n) |-> rd_low ##1 !flash_oe_n ##1
         flash_oe_n)
      else $error("read phase not nine cycles");
   read_toggle_a:
      assert property ($rose(flash_oe_n) |-> flash_oe_n[*8])
      else $error("output enable not toggled between reads");
endmodule
bind fps_sequencer fps_sequencer_chk #(.ADDR_W(ADDR_W)) u_chk (
   .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .irq(irq), .flash_addr(flash_addr),
   .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
   .flash_we_n(flash_we_n), .flash_dq_out(flash_dq_out),
   .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in)
);
`default_nettype wire

// >>> tb/fps_flash_model.sv
// Behavioural flash device answering the sequencer's strobes
`timescale 1ns/100ps
`default_nettype none
module fps_flash_model #(
   parameter int ADDR_W = 22,
   parameter int BUSY_READS = 3, // Status reads until ready shows
   parameter int USER_N = 4 // User area size code: 2**n bytes
) (
   input wire logic [ADDR_W-1:0] flash_addr,
   input wire logic flash_ce_n,
   input wire logic flash_oe_n,
   input wire logic flash_we_n,
   input wire logic [15:0] flash_dq_out,
   input wire logic flash_dq_oe,
   input wire logic [2:0] fault, // Injected: fail, supply, locked
   output logic [15:0] flash_dq_in
);
   logic [15:0] cmd_log [64]; // Every word written, in order
   logic [ADDR_W-1:0] adr_log [64];
   logic [7:0] sts = 8'h00; // Sticky error bits
   logic [15:0] drv = 16'hffff;
   logic armed = 1'b0; // Setup seen, data words expected
   logic stat_mode = 1'b0;
   int n_wr = 0;
   int n_rd = 0;
   int busy = 0;
   logic [15:0] sec_mem [128:140]; // Lock word, unique number, user words
   logic prot = 1'b0; // Last setup was the protection program
   // Unique number values are arbitrary; user words start erased
   initial begin
      foreach (sec_mem[i]) begin
         sec_mem[i] = (i < 133) ? 16'h3c00 + i[15:0] : 16'hffff;
      end
      sec_mem[128] = 16'h0002;
   end
   // Query words that describe the security area
   function automatic logic [15:0] query(input int a);
      case (a)
         32'h44: query = 16'h0080;
         32'h46: query = 16'h0003;
         32'h47: query = 16'(USER_N);
         default: query = 16'h0000;
      endcase
   endfunction
   assign flash_dq_in = drv;
   // Latch at the rising write strobe; guard skips reset edges
   always @(posedge flash_we_n) begin
      if (flash_dq_oe === 1'b1) begin
         cmd_log[n_wr] = flash_dq_out;
         adr_log[n_wr] = flash_addr;
         n_wr++;
         if (armed) begin
            busy = BUSY_READS;
            // A protection program can only clear bits of its word
            if (prot && flash_addr >= 128 && flash_addr <= 140) begin
               sec_mem[flash_addr] &= flash_dq_out;
            end
         end else if (flash_dq_out == 16'h00c0 ||
               flash_dq_out == 16'h0040) begin
            armed = 1'b1;
            prot = (flash_dq_out == 16'h00c0);
            stat_mode = 1'b1;
         end else if (flash_dq_out == 16'h0050) begin
            sts = 8'h00;
         end else if (flash_dq_out == 16'h00ff) begin
            stat_mode = 1'b0;
         end
      end
   end
   // Each new read phase presents a refreshed status word
   always @(negedge flash_oe_n) begin
      n_rd++;
      armed = 1'b0;
      if (busy > 0) begin
         busy--;
         if (busy == 0) begin
            sts = sts | {3'b000, fault[2:1], 1'b0, fault[0], 1'b0};
         end
      end
      drv = stat_mode ? {8'h00, busy == 0, sts[6:0]} : 16'h0000;
   end
   // Released bus shows the inverse, so stale data never passes
   always @(posedge flash_oe_n) drv = ~drv;
endmodule
`default_nettype wire

// >>> tb/fps_sequencer_tb_top.sv
// Self-checking bench: APB tasks drive the sequencer against a flash model
`timescale 1ns/100ps
`default_nettype none
`include "fps_regs.svh"
module fps_sequencer_tb_top;
   localparam logic [7:0] SR_ERR [3] = '{8'h02, 8'h08, 8'h10};
   logic sys_clk, rst, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic irq, ce_n, oe_n, we_n, dq_oe;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, q;
   logic [21:0] f_addr;
   logic [15:0] dq_out, dq_in;
   logic [2:0] fault = 0;
   int n_mismatch = 0;
   int n_tests = 0;
   int cycles = 0;
   int n0;
   fps_sequencer #(.ADDR_W(22)) u_dut (.sys_clk(sys_clk), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq), .flash_addr(f_addr), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
      .flash_we_n(we_n), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
      .flash_dq_in(dq_in));
   fps_flash_model #(.ADDR_W(22), .BUSY_READS(3)) u_flash (
      .flash_addr(f_addr), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
      .flash_we_n(we_n), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
      .fault(fault), .flash_dq_in(dq_in));
   // Free-running 125 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   // Hang guard: all traffic needs a few thousand cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end
   task automatic stop_test();
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One APB transfer held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a,
         input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      q = prdata;
      q[31] = (a == 12'h020) ? pslverr : q[31];
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   // Start one program operation and check the flash traffic it made
   task automatic op(input logic [1:0] m, input int bi,
         input logic [7:0] es, input logic [21:0] ba);
      int r0, nd, k;
      nd = (m == 2'h3) ? 4 : (m == 2'h2) ? 2 : 1;
      apb(1'b1, `FPS_ADDR_OFF, {10'h0, ba});
      for (k = 0; k < nd; k++) begin
         apb(1'b1, `FPS_DATA_OFF, {14'h0, k[1:0], 16'ha5c0 + k[15:0]});
      end
      n0 = u_flash.n_wr;
      r0 = u_flash.n_rd;
      apb(1'b1, `FPS_CTRL_OFF, {28'h0, m, 2'b01});
      do apb(1'b0, `FPS_STAT_OFF, 0); while (q[8] !== 1'b1);
      chk("flash_status", {24'h0, es}, {24'h0, q[7:0]});
      chk("writes", nd + 2, u_flash.n_wr - n0);
      chk("setup_cmd", (m == 2'h0) ? 32'hc0 : 32'h40,
         u_flash.cmd_log[n0]);
      for (k = 0; k < nd; k++) begin
         chk("word", 32'ha5c0 + k, u_flash.cmd_log[n0 + 1 + k]);
         chk("word_addr", ba | k, u_flash.adr_log[n0 + 1 + k]);
      end
      chk("status_reads", 3, u_flash.n_rd - r0);
      chk("array_cmd", 32'hff, u_flash.cmd_log[n0 + nd + 1]);
      apb(1'b0, `FPS_IRQ_OFF, 0);
      chk("irq_cause", 1, q[bi]);
   endtask
   // Clear all interrupt causes and see the line drop
   task automatic irq_clr();
      apb(1'b1, `FPS_IRQ_OFF, 32'h7);
      @(posedge sys_clk);
      chk("irq_low", 0, irq);
   endtask
   // Main sequence
   initial begin
      rst = 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      apb(1'b0, `FPS_STAT_OFF, 0);
      chk("idle_at_reset", 1, q[8]);
      apb(1'b0, `FPS_MASK_OFF, 0);
      chk("mask_reset", 0, q);
      apb(1'b0, 12'h020, 0);
      chk("unmapped_err", 1, q[31]);
      op(2'h0, 0, 8'h80, 22'h012344);
      chk("irq_masked", 0, irq);
      apb(1'b1, `FPS_MASK_OFF, 32'h7);
      @(posedge sys_clk);
      chk("irq_unmasked", 1, irq);
      irq_clr();
      for (int m = 1; m < 4; m++) begin
         op(m[1:0], 0, 8'h80, 22'h012344);
         irq_clr();
      end
      for (int f = 0; f < 3; f++) begin
         fault <= 3'b001 << f;
         op(2'h1, 1, 8'h80 | SR_ERR[f], 22'h012344);
         fault <= 3'b000;
         irq_clr();
         n0 = u_flash.n_wr;
         apb(1'b1, `FPS_CTRL_OFF, 32'h5);
         repeat (40) @(posedge sys_clk);
         chk("refused_writes", 0, u_flash.n_wr - n0);
         apb(1'b0, `FPS_IRQ_OFF, 0);
         chk("refused_irq", 1, q[2]);
         irq_clr();
         apb(1'b1, `FPS_CTRL_OFF, 32'h2);
         do apb(1'b0, `FPS_STAT_OFF, 0); while (q[8] !== 1'b1);
         chk("err_pending", 0, q[9]);
         chk("clear_cmd", 32'h50, u_flash.cmd_log[n0]);
         chk("clear_exit", 32'hff, u_flash.cmd_log[n0 + 1]);
      end
      op(2'h2, 0, 8'h80, 22'h012344);
      // Protection program into the first user one-time word
      op(2'h0, 0, 8'h80, 22'h000085);
      chk("otp_word", 32'ha5c0, u_flash.sec_mem[133]);
      chk("lock_upper", 0, u_flash.sec_mem[128][15:8]);
      chk("lock_ptr", 32'h80, u_flash.query(32'h44));
      chk("uid_bytes", 8, 1 << u_flash.query(32'h46));
      chk("otp_bytes", 16, 1 << u_flash.query(32'h47));
      stop_test();
   end
endmodule
`default_nettype wire
